// File: ccds_pkg.sv
// Constants and state types for the CC detect status register bank.
// Assumes a 40 MHz device clock and 32-bit AHB-Lite register access.
package ccds_pkg;
   // Clock and time base.
   localparam int unsigned CLK_NS = 25;
   localparam int unsigned T_100US_NS = 100000;
   localparam int unsigned T_1600US_NS = 1600000;
   localparam int unsigned TICK_CYC = T_100US_NS / CLK_NS;
   localparam int unsigned LONG_TICKS = T_1600US_NS / T_100US_NS;
   localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
   localparam logic [3:0] LONG_LAST = 4'(LONG_TICKS - 1);
   ////////////////////////////////////////////////////////////////////
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] IDX_CTL = 16'h0800;
   localparam logic [15:0] IDX_DEB = 16'h0801;
   localparam logic [15:0] IDX_EVT = 16'h0803;
   localparam logic [15:0] IDX_CHG1 = 16'h0804;
   localparam logic [15:0] IDX_CHG2 = 16'h0805;
   localparam logic [15:0] IDX_HIT1 = 16'h0806;
   localparam logic [15:0] IDX_HIT2 = 16'h0807;
   localparam logic [15:0] A_CTL = {IDX_CTL[13:0], 2'b00};
   localparam logic [15:0] A_DEB = {IDX_DEB[13:0], 2'b00};
   localparam logic [15:0] A_EVT = {IDX_EVT[13:0], 2'b00};
   localparam logic [15:0] A_CHG1 = {IDX_CHG1[13:0], 2'b00};
   localparam logic [15:0] A_CHG2 = {IDX_CHG2[13:0], 2'b00};
   localparam logic [15:0] A_HIT1 = {IDX_HIT1[13:0], 2'b00};
   localparam logic [15:0] A_HIT2 = {IDX_HIT2[13:0], 2'b00};
   ////////////////////////////////////////////////////////////////////
   // Control register fields.
   localparam int unsigned B_SOLO = 0;
   localparam int unsigned B_ROLE = 2;
   localparam int unsigned B_CMPEN = 3;
   localparam int unsigned B_UNIT = 11;
   localparam int unsigned B_ADV = 12;
   // Event register fields.
   localparam int unsigned B_VLD = 7;
   localparam int unsigned B_PUC = 6;
   localparam int unsigned B_DET = 5;
   localparam int unsigned B_ATT = 4;
   localparam int unsigned B_SUM2 = 1;
   localparam int unsigned B_SUM1 = 0;
   // Match register defaults by role.
   localparam logic [7:0] HITS_DFP = 8'hFF;
   localparam logic [7:0] HITS_UFP = 8'h00;
   // Attachment states reported by the attach logic.
   localparam logic [1:0] PS_UNATT = 2'h0;
   localparam logic [1:0] PS_WAIT = 2'h1;
   ////////////////////////////////////////////////////////////////////
   // Whole state of the bank.
   typedef struct packed {
      logic [1:0][7:0] raw_m;
      logic [1:0][7:0] raw_s;
      logic [1:0][7:0] raw_h;
      logic [1:0][7:0] hits;
      logic [1:0][7:0] chg;
      logic [1:0][7:0] dcnt;
      logic [1:0][7:0] dbclr;
      logic [11:0] div;
      logic [3:0] div16;
      logic vbus_m;
      logic vbus_s;
      logic strap_m;
      logic strap_s;
      logic [1:0] init;
      logic conn_p;
      logic cv_p;
      logic vbus_p;
      logic [1:0] adv_p;
      logic solo;
      logic role;
      logic cmpen;
      logic unit;
      logic [7:0] mdeb;
      logic [7:0] pddeb;
      logic vld;
      logic fired;
      logic puc;
      logic det;
      logic att;
      logic wr;
      logic [15:0] waddr;
      logic [31:0] rdata;
   } ccds_state_t;
endpackage

// File: ccds_regs.sv
// CC detect status register bank: match, change and event flags.
// Assumes comparator and strap pins are asynchronous and the attach
// logic (port state, connection, vopen, advertisement) runs on clock_i.
// Function
// - Flag first valid match after debouncer enable.
// - Standalone UFP flags pull-up advertisement change.
// - Pull-up change flag reads zero otherwise.
// - New advertisement readable in control register.
// - Standalone detach: DFP from CC, UFP VBUS.
// - Standalone attach: DFP CC, UFP CC plus VBUS.
// - Event sources are pulses; cleared stays clear.
// - Read-only per-pin change summary flags.
// - Change bit set when match bit changes.
// - Write one clears only those change bits.
// - Match bit means voltage exceeds threshold.
// - Unattached: update after match debounce interval.
// - AttachWait: update after PD debounce with vopen.
// - Attached: update after PD debounce interval.
// - Companion mode shows default until comparator enabled.
// - Debounced where enabled, else raw result.
// - Match default FFh as DFP, 00h UFP.
// - Match debounce steps 1.6 ms or 100 us.
// - Role bit: zero UFP, one DFP.
`timescale 1ns/1ps
module ccds_regs
(
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // AHB-Lite slave.
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Comparator and pin inputs, asynchronous.
   input wire logic [7:0] cc1_cmp_i,
   input wire logic [7:0] cc2_cmp_i,
   input wire logic vbus_valid_i,
   input wire logic role_strap_i,
   // Attach logic, same clock.
   input wire logic [1:0] port_state_i,
   input wire logic vopen_i,
   input wire logic cc_conn_i,
   input wire logic [1:0] adv_current_i,
   // Presented match results.
   output logic [7:0] cc1_hits_o,
   output logic [7:0] cc2_hits_o
);

   ////////////////////////////////////////////////////////////////////
   // Reset release through two flops; assertion stays asynchronous.
   logic rst_m_q;
   logic rst_n_q;
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register read decode, used only by the bus read path.
   ccds_pkg::ccds_state_t s_q;
   ccds_pkg::ccds_state_t s_d;
   logic puc_mode;
   logic enabled;
   logic [15:0] evt_word;

   function automatic logic [31:0] read_reg(input ccds_pkg::ccds_state_t s, input logic [15:0] a,
                                            input logic [15:0] evt);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         ccds_pkg::A_CTL:
         begin
            r[ccds_pkg::B_SOLO] = s.solo;
            r[ccds_pkg::B_ROLE] = s.role;
            r[ccds_pkg::B_CMPEN] = s.cmpen;
            r[ccds_pkg::B_UNIT] = s.unit;
            r[ccds_pkg::B_ADV +: 2] = s.adv_p;
         end
         ccds_pkg::A_DEB: r = {s.dbclr[1], s.dbclr[0], s.pddeb, s.mdeb};
         ccds_pkg::A_EVT: r = {16'h0000, evt};
         ccds_pkg::A_CHG1: r = {24'h000000, s.chg[0]};
         ccds_pkg::A_CHG2: r = {24'h000000, s.chg[1]};
         ccds_pkg::A_HIT1: r = {24'h000000, s.hits[0]};
         ccds_pkg::A_HIT2: r = {24'h000000, s.hits[1]};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // Flag word; reserved bits and the pull-up flag outside its mode read zero.
   always_comb
   begin
      evt_word = 16'h0000;
      evt_word[ccds_pkg::B_VLD] = s_q.vld;
      evt_word[ccds_pkg::B_PUC] = s_q.puc & puc_mode;
      evt_word[ccds_pkg::B_DET] = s_q.det;
      evt_word[ccds_pkg::B_ATT] = s_q.att;
      evt_word[ccds_pkg::B_SUM2] = |s_q.chg[1];
      evt_word[ccds_pkg::B_SUM1] = |s_q.chg[0];
   end

   assign puc_mode = s_q.solo & ~s_q.role;
   assign enabled = s_q.solo | s_q.cmpen;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole bank.
   logic tick100;
   logic tick1600;
   logic unit_tick;
   logic unatt;
   logic sel;
   logic ufp_cv;
   logic [1:0] settled;
   logic [7:0] dflt;
   logic [7:0] wmask;
   logic [7:0] differ;
   logic [7:0] lim;
   logic tk;
   logic run;

   always_comb
   begin
      s_d = s_q;
      wmask = 8'h00;
      differ = 8'h00;
      settled = 2'b00;
      // Pin inputs pass two flops before anything looks at them.
      s_d.raw_m = {cc2_cmp_i, cc1_cmp_i};
      s_d.raw_s = s_q.raw_m;
      s_d.raw_h = s_q.raw_s;
      s_d.vbus_m = vbus_valid_i;
      s_d.vbus_s = s_q.vbus_m;
      s_d.strap_m = role_strap_i;
      s_d.strap_s = s_q.strap_m;
      // Role strap is caught once the synchroniser has filled.
      if (s_q.init != 2'h3)
      begin
         s_d.init = s_q.init + 2'h1;
         if (s_q.init == 2'h2)
         begin
            s_d.role = s_q.strap_s;
         end
      end
      // Time base: 100 us enable pulse, and every sixteenth one.
      tick100 = (s_q.div == ccds_pkg::TICK_LAST);
      tick1600 = tick100 && (s_q.div16 == ccds_pkg::LONG_LAST);
      s_d.div = tick100 ? 12'h000 : s_q.div + 12'h001;
      if (tick100)
      begin
         s_d.div16 = tick1600 ? 4'h0 : s_q.div16 + 4'h1;
      end
      unit_tick = s_q.unit ? tick100 : tick1600;
      unatt = (port_state_i == ccds_pkg::PS_UNATT);
      // The unattached interval uses its unit; the PD interval counts 100 us.
      lim = unatt ? s_q.mdeb : s_q.pddeb;
      tk = unatt ? unit_tick : tick100;
      run = (port_state_i != ccds_pkg::PS_WAIT) || vopen_i;
      dflt = s_q.role ? ccds_pkg::HITS_DFP : ccds_pkg::HITS_UFP;
      // Per-pin match presentation.
      for (int p = 0; p < 2; p++)
      begin
         if (!enabled)
         begin
            s_d.hits[p] = dflt;
            s_d.dcnt[p] = 8'h00;
         end
         else
         begin
            // A set bit means the level is above that threshold.
            differ = (s_q.raw_s[p] ^ s_q.hits[p]) & s_q.dbclr[p];
            s_d.hits[p] = (s_q.raw_s[p] & ~s_q.dbclr[p]) | (s_q.hits[p] & s_q.dbclr[p]);
            settled[p] = (differ == 8'h00);
            // Any movement of the raw value restarts the interval.
            if (settled[p] || (s_q.raw_s[p] != s_q.raw_h[p]) || !run)
            begin
               s_d.dcnt[p] = 8'h00;
            end
            else if (s_q.dcnt[p] >= lim)
            begin
               s_d.hits[p] = s_q.raw_s[p];
               s_d.dcnt[p] = 8'h00;
            end
            else if (tk)
            begin
               s_d.dcnt[p] = s_q.dcnt[p] + 8'h01;
            end
         end
      end
      // Data phase of a write: control and interval registers.
      if (s_q.wr)
      begin
         case (s_q.waddr)
            ccds_pkg::A_CTL:
            begin
               s_d.solo = hwdata_i[ccds_pkg::B_SOLO];
               s_d.role = hwdata_i[ccds_pkg::B_ROLE];
               s_d.cmpen = hwdata_i[ccds_pkg::B_CMPEN];
               s_d.unit = hwdata_i[ccds_pkg::B_UNIT];
            end
            ccds_pkg::A_DEB:
            begin
               s_d.mdeb = hwdata_i[7:0];
               s_d.pddeb = hwdata_i[15:8];
               s_d.dbclr[0] = hwdata_i[23:16];
               s_d.dbclr[1] = hwdata_i[31:24];
            end
            default: wmask = 8'h00;
         endcase
      end
      // Change flags: clear the ones written, then set wins.
      for (int p = 0; p < 2; p++)
      begin
         wmask = (s_q.wr && (s_q.waddr == (p == 0 ? ccds_pkg::A_CHG1 : ccds_pkg::A_CHG2))) ?
                 hwdata_i[7:0] : 8'h00;
         s_d.chg[p] = (s_q.chg[p] & ~wmask) | (s_q.hits[p] ^ s_d.hits[p]);
      end
      // Event flags: clear when written as one, a new event wins.
      wmask = (s_q.wr && (s_q.waddr == ccds_pkg::A_EVT)) ? hwdata_i[7:0] : 8'h00;
      s_d.vld = s_q.vld & ~wmask[ccds_pkg::B_VLD];
      s_d.puc = s_q.puc & ~wmask[ccds_pkg::B_PUC] & puc_mode;
      s_d.det = s_q.det & ~wmask[ccds_pkg::B_DET];
      s_d.att = s_q.att & ~wmask[ccds_pkg::B_ATT];
      // First settled view after the debouncer starts raises the flag once.
      if (!enabled)
      begin
         s_d.fired = 1'b0;
      end
      else if (!s_q.fired && (settled == 2'b11))
      begin
         s_d.fired = 1'b1;
         s_d.vld = 1'b1;
      end
      // Advertisement changes are edges, so one change sets the flag once.
      s_d.adv_p = adv_current_i;
      if (puc_mode && (adv_current_i != s_q.adv_p))
      begin
         s_d.puc = 1'b1;
      end
      // Attach and detach edges in standalone mode.
      ufp_cv = cc_conn_i & s_q.vbus_s;
      s_d.conn_p = cc_conn_i;
      s_d.cv_p = ufp_cv;
      s_d.vbus_p = s_q.vbus_s;
      if (s_q.solo)
      begin
         if (s_q.role ? (cc_conn_i && !s_q.conn_p) : (ufp_cv && !s_q.cv_p))
         begin
            s_d.att = 1'b1;
         end
         if (s_q.role ? (!cc_conn_i && s_q.conn_p) : (!s_q.vbus_s && s_q.vbus_p))
         begin
            s_d.det = 1'b1;
         end
      end
      // Address phase: capture writes, fetch read data for the data phase.
      sel = hsel_i && htrans_i[1] && hready_i;
      s_d.wr = sel && hwrite_i;
      s_d.waddr = haddr_i[15:0];
      s_d.rdata = (sel && !hwrite_i) ? read_reg(s_q, haddr_i[15:0], evt_word) : 32'h0000_0000;
   end

   // One register for the whole state; reset clears everything.
   always_ff @(posedge clock_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Zero wait states, always OKAY.
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = s_q.rdata;
   assign cc1_hits_o = s_q.hits[0];
   assign cc2_hits_o = s_q.hits[1];

   ////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_q);

   chk_first_valid: assert property (enabled && !s_q.fired && s_d.fired |=> s_q.vld)
      else $error("first match flag not raised");
   // The pull-up flag is watched in its own register, so a mode change cannot mask a miss.
   chk_pullup_set: assert property (puc_mode && (adv_current_i != s_q.adv_p) |=> s_q.puc)
      else $error("pull-up change missed");
   chk_pullup_zero: assert property (!puc_mode |=> !s_q.puc)
      else $error("pull-up flag visible outside mode");
   chk_attach_dfp: assert property (s_q.solo && s_q.role && cc_conn_i && !s_q.conn_p |=> s_q.att)
      else $error("dfp attach missed");
   chk_detach_ufp: assert property (s_q.solo && !s_q.role && s_q.vbus_p && !s_q.vbus_s |=> s_q.det)
      else $error("ufp detach missed");
   chk_change_set: assert property ($changed(s_q.hits[0]) |->
      ((s_q.chg[0] & (s_q.hits[0] ^ $past(s_q.hits[0]))) == (s_q.hits[0] ^ $past(s_q.hits[0]))))
      else $error("change bit not set");
   chk_default_show: assert property (!enabled && s_q.role |=> (s_q.hits == {2{8'hFF}}))
      else $error("default match value not shown");
   // The upstream-facing default is all zeros while the debouncer is off.
   chk_default_ufp: assert property (!enabled && !s_q.role |=> (s_q.hits == {2{8'h00}}))
      else $error("upstream default not shown");
   // Summary bits are checked through the read path, not the flag word itself.
   chk_summary: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i &&
      (haddr_i[15:0] == ccds_pkg::A_EVT) |=> (hrdata_o[1:0] == {|$past(s_q.chg[1]), |$past(s_q.chg[0])}))
      else $error("summary flag wrong");
   chk_raw_pass: assert property (enabled && (s_q.dbclr[0] == 8'h00) ##1 enabled |->
      (s_q.hits[0] == $past(s_q.raw_s[0])))
      else $error("raw match not shown");
   // Attach-wait without an open line keeps every debounced bit of pin 1.
   chk_wait_hold: assert property (enabled && (port_state_i == ccds_pkg::PS_WAIT) && !vopen_i |=>
      (((s_q.hits[0] ^ $past(s_q.hits[0])) & $past(s_q.dbclr[0])) == 8'h00))
      else $error("match moved in attach wait");
   // Bits written as zero to a change register stay set.
   chk_w1c_keep: assert property (s_q.wr && (s_q.waddr == ccds_pkg::A_CHG1) |=>
      ((~$past(hwdata_i[7:0]) & $past(s_q.chg[0]) & ~s_q.chg[0]) == 8'h00))
      else $error("change bit lost on write");
   // Remaining standalone edges: upstream attach and downstream detach.
   chk_attach_ufp: assert property (s_q.solo && !s_q.role && ufp_cv && !s_q.cv_p |=> s_q.att)
      else $error("ufp attach missed");
   chk_detach_dfp: assert property (s_q.solo && s_q.role && !cc_conn_i && s_q.conn_p |=> s_q.det)
      else $error("dfp detach missed");

endmodule // ccds_regs

// File: test_cc_detect_status_regs.sv
// Self-checking bench for the CC detect status register bank.
// Drives the AHB-Lite port and the pin inputs directly.
// The one slave's hreadyout is fed back as hready.
`timescale 1ns/1ps
module test_cc_detect_status_regs;
   logic clk, rst_n, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, port_state, adv;
   logic [7:0] cmp1, cmp2, hits1, hits2;
   logic vbus, strap, vopen, conn, hrdy, hresp;
   int failures = 0;
   int compares = 0;
   ////////////////////////////////////////////////////////////////////
   // Device under test.
   ccds_regs i_ccds_regs (.clock_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
      .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .cc1_cmp_i(cmp1), .cc2_cmp_i(cmp2),
      .vbus_valid_i(vbus), .role_strap_i(strap), .port_state_i(port_state), .vopen_i(vopen),
      .cc_conn_i(conn), .adv_current_i(adv), .cc1_hits_o(hits1), .cc2_hits_o(hits2));
   ////////////////////////////////////////////////////////////////////
   // Clock at 40 MHz.
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Compare one value and count the outcome.
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask
   // One single transfer; the request is held until hready is seen high.
   task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {16'h0000, a};
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      logic [31:0] d;
      bus(a, 1'b1, v, d);
   endtask
   // Read a register and compare the bits selected by the mask.
   task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      bus(a, 1'b0, 32'h0000_0000, d);
      chk(n, d & m, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // The run ends here, from the main sequence or from the watchdog.
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Watchdog; the sequence needs about 36500 cycles.
   initial
   begin
      repeat (60000) @(posedge clk);
      failures++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      cmp1 = 8'h5A;
      cmp2 = 8'h3C;
      vbus = 1'b0;
      strap = 1'b0;
      port_state = ccds_pkg::PS_UNATT;
      vopen = 1'b0;
      conn = 1'b0;
      adv = 2'h0;
      idle(5);
      rst_n <= 1'b1;
      idle(6);
      // Upstream-facing strap, comparator off: upstream default shown.
      rchk("ctl_role", ccds_pkg::A_CTL, 32'h0000_0004, 32'h0000_0000);
      rchk("hit1_ufp", ccds_pkg::A_HIT1, 32'hFFFF_FFFF, 32'h0000_0000);
      rchk("chg1_rst", ccds_pkg::A_CHG1, 32'hFFFF_FFFF, 32'h0000_0000);
      // Switching to downstream-facing moves the default to all ones.
      wr(ccds_pkg::A_CTL, 32'h0000_0004);
      idle(4);
      chk("hits1_port", {24'h0, hits1}, 32'h0000_00FF);
      rchk("hit2_dfp", ccds_pkg::A_HIT2, 32'hFFFF_FFFF, 32'h0000_00FF);
      rchk("chg1_move", ccds_pkg::A_CHG1, 32'hFFFF_FFFF, 32'h0000_00FF);
      rchk("evt_sum", ccds_pkg::A_EVT, 32'h0000_000F, 32'h0000_0003);
      // Partial write-one-to-clear leaves the zero bits alone.
      wr(ccds_pkg::A_CHG1, 32'h0000_000F);
      rchk("chg1_part", ccds_pkg::A_CHG1, 32'hFFFF_FFFF, 32'h0000_00F0);
      wr(ccds_pkg::A_CHG1, 32'h0000_00F0);
      wr(ccds_pkg::A_CHG2, 32'h0000_00FF);
      rchk("chg2_clr", ccds_pkg::A_CHG2, 32'hFFFF_FFFF, 32'h0000_0000);
      rchk("evt_sum0", ccds_pkg::A_EVT, 32'hFFFF_FFFF, 32'h0000_0000);
      // Read-only and unmapped places.
      wr(ccds_pkg::A_HIT1, 32'h0000_0000);
      rchk("hit1_ro", ccds_pkg::A_HIT1, 32'hFFFF_FFFF, 32'h0000_00FF);
      rchk("unmapped", 16'h2008, 32'hFFFF_FFFF, 32'h0000_0000);
      // Pin 1 debounced over two 100 us steps, pin 2 raw.
      wr(ccds_pkg::A_DEB, 32'h00FF_0102);
      wr(ccds_pkg::A_CTL, 32'h0000_080C);
      idle(4);
      rchk("hit2_raw", ccds_pkg::A_HIT2, 32'hFFFF_FFFF, 32'h0000_003C);
      rchk("hit1_wait", ccds_pkg::A_HIT1, 32'hFFFF_FFFF, 32'h0000_00FF);
      rchk("vld_early", ccds_pkg::A_EVT, 32'h0000_0080, 32'h0000_0000);
      idle(12000);
      rchk("hit1_deb", ccds_pkg::A_HIT1, 32'hFFFF_FFFF, 32'h0000_005A);
      chk("hits2_port", {24'h0, hits2}, 32'h0000_003C);
      rchk("chg1_bits", ccds_pkg::A_CHG1, 32'hFFFF_FFFF, 32'h0000_00A5);
      rchk("chg2_bits", ccds_pkg::A_CHG2, 32'hFFFF_FFFF, 32'h0000_00C3);
      rchk("evt_vld", ccds_pkg::A_EVT, 32'hFFFF_FFFF, 32'h0000_0083);
      wr(ccds_pkg::A_EVT, 32'h0000_0080);
      idle(4);
      rchk("vld_clr", ccds_pkg::A_EVT, 32'h0000_00FC, 32'h0000_0000);
      // Companion mode: the pull-up change flag stays zero.
      adv <= 2'h2;
      idle(4);
      rchk("puc_comp", ccds_pkg::A_EVT, 32'h0000_0040, 32'h0000_0000);
      // Standalone upstream-facing: advertisement change is flagged.
      wr(ccds_pkg::A_CTL, 32'h0000_0809);
      idle(4);
      adv <= 2'h1;
      idle(4);
      rchk("puc_set", ccds_pkg::A_EVT, 32'h0000_0040, 32'h0000_0040);
      rchk("adv_field", ccds_pkg::A_CTL, 32'h0000_3000, 32'h0000_1000);
      wr(ccds_pkg::A_EVT, 32'h0000_0040);
      idle(4);
      rchk("puc_clr", ccds_pkg::A_EVT, 32'h0000_0040, 32'h0000_0000);
      // Upstream attach needs both CC and VBUS; detach follows VBUS.
      conn <= 1'b1;
      idle(6);
      rchk("att_novbus", ccds_pkg::A_EVT, 32'h0000_0030, 32'h0000_0000);
      vbus <= 1'b1;
      idle(6);
      rchk("att_ufp", ccds_pkg::A_EVT, 32'h0000_0030, 32'h0000_0010);
      vbus <= 1'b0;
      idle(6);
      rchk("det_ufp", ccds_pkg::A_EVT, 32'h0000_0030, 32'h0000_0030);
      wr(ccds_pkg::A_EVT, 32'h0000_0030);
      conn <= 1'b0;
      idle(6);
      rchk("ev_clr", ccds_pkg::A_EVT, 32'h0000_0030, 32'h0000_0000);
      // Standalone downstream-facing: CC alone gives attach and detach.
      wr(ccds_pkg::A_CTL, 32'h0000_080D);
      idle(4);
      wr(ccds_pkg::A_EVT, 32'h0000_0070);
      conn <= 1'b1;
      idle(6);
      rchk("att_dfp", ccds_pkg::A_EVT, 32'h0000_0030, 32'h0000_0010);
      conn <= 1'b0;
      adv <= 2'h3;
      idle(6);
      rchk("det_dfp", ccds_pkg::A_EVT, 32'h0000_0030, 32'h0000_0030);
      rchk("puc_dfp", ccds_pkg::A_EVT, 32'h0000_0040, 32'h0000_0000);
      // Attached: pin 1 settles after one 100 us step of the PD interval.
      port_state <= 2'h2;
      cmp1 <= 8'hA5;
      idle(4100);
      chk("hits1_att", {24'h0, hits1}, 32'h0000_00A5);
      // Attach-wait holds the old view until the open line is seen.
      port_state <= ccds_pkg::PS_WAIT;
      cmp1 <= 8'h5A;
      idle(4100);
      chk("hits1_hold", {24'h0, hits1}, 32'h0000_00A5);
      vopen <= 1'b1;
      idle(4100);
      chk("hits1_open", {24'h0, hits1}, 32'h0000_005A);
      // With 1.6 ms steps, two steps cannot pass within 12000 cycles.
      port_state <= ccds_pkg::PS_UNATT;
      wr(ccds_pkg::A_CTL, 32'h0000_000D);
      cmp1 <= 8'hA5;
      idle(12000);
      rchk("hit1_long", ccds_pkg::A_HIT1, 32'hFFFF_FFFF, 32'h0000_005A);
      test_done();
   end
endmodule // test_cc_detect_status_regs
